// ===== hw/rep_pkg.sv
package rep_pkg;
  // clock and line rates
  localparam int CLK_NS   = 10;                        // system clock period
  localparam int BIT_NS   = 10;                        // one bit time at 100 Mb/s
  localparam int SYM_BITS = 4;                         // bits per symbol (nibble)
  localparam int SYM_DIV  = SYM_BITS * BIT_NS / CLK_NS; // clocks per symbol
  localparam int NPORTS_DEF = 4;                       // default port count
  localparam int PRE_NIB  = 14;                        // regenerated preamble nibbles
  // start-of-packet variability limits, in tenths of a bit time
  localparam int VAR_GAP_BT     = 104;                 // packet spacing that applies
  localparam int VAR_TXFX_BT10  = 70;                  // 7.0 BT
  localparam int VAR_T4T2_BT10  = 80;                  // 8.0 BT
  localparam int VAR_TXFX_CYC   = VAR_TXFX_BT10 * BIT_NS / (10 * CLK_NS);
  localparam int VAR_T4T2_CYC   = VAR_T4T2_BT10 * BIT_NS / (10 * CLK_NS);
  // symbol values on the abstract nibble path
  localparam logic [3:0] IDLE_NIB = 4'h0;              // idle fill
  localparam logic [3:0] PRE_VAL  = 4'h5;              // preamble nibble
  localparam logic [3:0] SFD_VAL  = 4'hD;              // frame delimiter nibble
  localparam logic [3:0] JAM_VAL  = 4'h5;              // jam pattern nibble
  localparam logic [3:0] ERR_SEL_BAD = 4'h1;           // bad_code selector
  localparam logic [3:0] ERR_SEL_H   = 4'h2;           // halt code-group selector
  localparam logic [3:0] ERR_SEL_ESC = 4'h3;           // escape pair selector

  // attached PHY family of each port
  typedef enum logic [1:0] {
    PHY_TXFX = 2'h0,
    PHY_T4   = 2'h1,
    PHY_T2   = 2'h2
  } phy_type_t;

  // kind of message sent toward a PMA
  typedef enum logic [2:0] {
    MSG_IDLE = 3'h0,
    MSG_PRE  = 3'h1,
    MSG_SFD  = 3'h2,
    MSG_DATA = 3'h3,
    MSG_ERR  = 3'h4,
    MSG_JAM  = 3'h5
  } msg_kind_t;

  // core sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PRE  = 5'h02,
    ST_SFD  = 5'h04,
    ST_DATA = 5'h08,
    ST_JAM  = 5'h10
  } rep_state_t;

  // one port's receive side
  typedef struct packed {
    logic       active;                                // carrier present
    logic       frame;                                 // nibble belongs to data frame
    logic       viol;                                  // code violation on this nibble
    logic [3:0] data;                                  // received nibble
  } rx_port_t;

  // one port's status from its PMA interface
  typedef struct packed {
    logic      en;                                     // port enabled
    logic      part;                                   // partitioned
    logic      jab;                                    // jabber state
    logic      unst;                                   // link unstable
    phy_type_t ptype;                                  // PHY family
  } port_ctl_t;

  // one port's transmit side
  typedef struct packed {
    msg_kind_t  kind;
    logic [3:0] data;
  } tx_port_t;

  // word held in the forwarding buffer
  typedef struct packed {
    logic       viol;
    logic [3:0] data;
  } fwd_word_t;
endpackage

// ===== hw/rep_fifo2.sv
`timescale 1ns/1ns
module rep_fifo2 #(
  parameter int W = 5
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic         flush_in,      // drop everything held
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  logic [W-1:0] head_r;                    // oldest word, read data register
  logic [W-1:0] tail_r;                    // second word
  logic [1:0]   count_r;                   // 0, 1 or 2 words held
  logic         push;
  logic         pop;

  if (W < 1) begin : g_bad
    $error("rep_fifo2: width must be positive");
  end

  assign in_ready_out  = (count_r != 2'h2);
  assign out_valid_out = (count_r != 2'h0);
  assign out_data_out  = head_r;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // storage and occupancy; a full buffer refuses, so the source sees the stall
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      head_r  <= '0;
      tail_r  <= '0;
      count_r <= 2'h0;
    end else if (flush_in) begin
      count_r <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_r == 2'h0) head_r <= in_data_in;
          else tail_r <= in_data_in;
          count_r <= count_r + 2'h1;
        end
        2'b01: begin
          head_r  <= tail_r;
          count_r <= count_r - 2'h1;
        end
        2'b11: begin
          // only reachable with one word held
          head_r <= in_data_in;
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// ===== hw/rep_port_lane.sv
`timescale 1ns/1ns
module rep_port_lane (
  input  wire logic          clk_sys_in,
  input  wire logic          rst_n_in,
  input  wire logic          step_in,      // symbol-rate update
  input  rep_pkg::rx_port_t  rx_in,
  input  rep_pkg::port_ctl_t ctl_in,
  input  rep_pkg::tx_port_t  msg_in,       // message from the core
  input  wire logic          is_src_in,    // this port is the repeated-from port
  output logic               sense_out,    // received event, gated
  output rep_pkg::tx_port_t  tx_out
);
  import rep_pkg::*;

  tx_port_t tx_r;                          // registered transmit symbol
  tx_port_t tx_nxt;

  // carrier of enabled, healthy ports only; idle never counts
  assign sense_out = rx_in.active & ctl_in.en & ~ctl_in.part
                   & ~ctl_in.jab & ~ctl_in.unst;

  // per-port output encoding
  always_comb begin
    tx_nxt.kind = MSG_IDLE;
    tx_nxt.data = IDLE_NIB;
    if (ctl_in.jab | ctl_in.unst) begin
      // such a port gets no output at all
      tx_nxt.kind = MSG_IDLE;
    end else if (msg_in.kind == MSG_JAM) begin
      tx_nxt = msg_in;
    end else if (is_src_in) begin
      // never echo the frame back to its sender
      tx_nxt.kind = MSG_IDLE;
    end else if (msg_in.kind == MSG_ERR) begin
      tx_nxt.kind = MSG_ERR;
      case (ctl_in.ptype)
        PHY_TXFX: tx_nxt.data = ERR_SEL_H;
        PHY_T4:   tx_nxt.data = ERR_SEL_BAD;
        PHY_T2:   tx_nxt.data = ERR_SEL_ESC;
        default:  tx_nxt.data = ERR_SEL_H;
      endcase
    end else begin
      tx_nxt = msg_in;
    end
  end

  // output register, moves only on a symbol step
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_r.kind <= MSG_IDLE;
      tx_r.data <= IDLE_NIB;
    end else if (step_in) begin
      tx_r <= tx_nxt;
    end
  end

  assign tx_out = tx_r;
endmodule

// ===== hw/multiport_repeater_core.sv
`timescale 1ns/1ns
module multiport_repeater_core #(
  parameter int NPORTS = rep_pkg::NPORTS_DEF
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_n_in,
  input  rep_pkg::rx_port_t  [NPORTS-1:0] rx_port_in,
  input  rep_pkg::port_ctl_t [NPORTS-1:0] port_ctl_in,
  input  wire logic                       tx_ready_in,
  output rep_pkg::tx_port_t  [NPORTS-1:0] tx_port_out,
  output logic                            rx_ready_out,
  output logic                            collision_out,
  output logic                            fwd_active_out,
  output logic               [NPORTS-1:0] src_port_out
);
  import rep_pkg::*;

  localparam int DW  = $clog2(SYM_DIV);    // divider width
  localparam int PCW = $clog2(PRE_NIB);    // preamble counter width
  localparam int FW  = $bits(fwd_word_t);  // buffer word width

  // refuse port counts the one-hot source select cannot serve
  if (NPORTS < 2 || NPORTS > 32) begin : g_bad_ports
    $error("multiport_repeater_core: NPORTS must be 2 to 32");
  end
  if (SYM_DIV < 2) begin : g_bad_div
    $error("multiport_repeater_core: symbol divider below 2");
  end
  if (VAR_TXFX_CYC < SYM_DIV || VAR_T4T2_CYC < SYM_DIV) begin : g_bad_var
    $error("multiport_repeater_core: divider jitter exceeds variability");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DW-1:0]     div_r;                // symbol divider
  logic              sym_en_r;             // one pulse per symbol period
  rep_state_t        state_r;              // sequencer state
  logic [PCW-1:0]    pre_cnt_r;            // preamble nibbles sent
  logic [NPORTS-1:0] src_r;                // one-hot repeated-from port
  logic              sub_r;                // error substitution sticky
  logic              ready_r;              // registered buffer space flag

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic [NPORTS-1:0] sense;                // gated activity per port
  logic              any_act;              // at least one port active
  logic              multi_act;            // two or more ports active
  logic [NPORTS-1:0] first_act;            // lowest active port, one-hot
  logic              src_act;              // source still active
  logic              src_frame;            // source nibble is frame data
  fwd_word_t         src_word;             // source nibble with violation
  logic              step;                 // symbol step with PMAs ready
  logic              forwarding;           // PRE, SFD or DATA
  logic              push_valid;           // frame nibble into buffer
  logic              push_ready;
  logic              pop_valid;
  logic              pop_ready;
  logic [FW-1:0]     pop_bits;
  fwd_word_t         pop_word;
  logic              flush;                // buffer drop
  tx_port_t          msg;                  // core message to all lanes

  // ---------------------------------------------------------------
  // symbol divider: one clock-wide enable per nibble period.
  // free running so the start of a packet lands on a fixed grid;
  // the grid alone costs at most SYM_DIV bit times of spread
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r    <= '0;
      sym_en_r <= 1'b0;
    end else begin
      sym_en_r <= (div_r == DW'(SYM_DIV - 1));
      if (div_r == DW'(SYM_DIV - 1)) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + DW'(1);
      end
    end
  end

  // a stalled PMA side freezes the output sequence
  assign step = sym_en_r & tx_ready_in;

  // ---------------------------------------------------------------
  // per-port lanes: activity sense and transmit encoding
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NPORTS; i++) begin : g_lane
    rep_port_lane u_lane (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .step_in    (step),
      .rx_in      (rx_port_in[i]),
      .ctl_in     (port_ctl_in[i]),
      .msg_in     (msg),
      .is_src_in  (src_r[i] & forwarding),
      .sense_out  (sense[i]),
      .tx_out     (tx_port_out[i])
    );
  end

  // ---------------------------------------------------------------
  // activity summary. contention is any two bits set, found with
  // the clear-lowest-bit trick instead of a full adder tree
  // ---------------------------------------------------------------
  assign any_act   = |sense;
  assign multi_act = |(sense & (sense - NPORTS'(1)));
  assign first_act = sense & (~sense + NPORTS'(1));
  assign src_act   = |(sense & src_r);

  // pick the source port's receive fields through the one-hot select
  always_comb begin
    src_frame     = 1'b0;
    src_word.viol = 1'b0;
    src_word.data = 4'h0;
    for (int i = 0; i < NPORTS; i++) begin
      if (src_r[i]) begin
        src_frame     = rx_port_in[i].frame;
        src_word.viol = rx_port_in[i].viol;
        src_word.data = rx_port_in[i].data;
      end
    end
  end

  assign forwarding = (state_r == ST_PRE) | (state_r == ST_SFD)
                    | (state_r == ST_DATA);

  // ---------------------------------------------------------------
  // forwarding buffer. only frame nibbles enter: the incoming
  // preamble is dropped and rebuilt, and the two entries absorb a
  // short PMA stall over the last frame nibble. the receive PHY cannot be
  // held, so a stall of one symbol before the last frame nibble loses data; rx_ready_out shows it
  // ---------------------------------------------------------------
  assign push_valid = sym_en_r & forwarding & src_act & src_frame;
  assign pop_ready  = step & (state_r == ST_DATA);
  // collision or idle discards whatever is held
  assign flush      = (state_r == ST_JAM) | (state_r == ST_IDLE);

  rep_fifo2 #(
    .W (FW)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (flush),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (src_word),
    .out_valid_out (pop_valid),
    .out_ready_in  (pop_ready),
    .out_data_out  (pop_bits)
  );

  assign pop_word = fwd_word_t'(pop_bits);

  // ---------------------------------------------------------------
  // core message, shared by all lanes
  // ---------------------------------------------------------------
  always_comb begin
    msg.kind = MSG_IDLE;
    msg.data = IDLE_NIB;
    case (state_r)
      ST_IDLE: begin
        msg.kind = MSG_IDLE;
      end
      ST_PRE: begin
        // rebuilt preamble, independent of what arrived
        msg.kind = MSG_PRE;
        msg.data = PRE_VAL;
      end
      ST_SFD: begin
        msg.kind = MSG_SFD;
        msg.data = SFD_VAL;
      end
      ST_DATA: begin
        if (pop_valid) begin
          // a violation, or any after one, goes out as error
          if (pop_word.viol | sub_r) begin
            msg.kind = MSG_ERR;
          end else begin
            msg.kind = MSG_DATA;
          end
          msg.data = pop_word.data;
        end else if (src_act) begin
          // underrun mid-frame: send invalid rather than a gap
          msg.kind = MSG_ERR;
        end else begin
          msg.kind = MSG_IDLE;
        end
      end
      ST_JAM: begin
        msg.kind = MSG_JAM;
        msg.data = JAM_VAL;
      end
      default: begin
        msg.kind = MSG_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r   <= ST_IDLE;
      pre_cnt_r <= '0;
      src_r     <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sym_en_r && multi_act) begin
            state_r <= ST_JAM;
          end else if (sym_en_r && any_act) begin
            // exactly one port: latch it and start the preamble
            state_r   <= ST_PRE;
            src_r     <= first_act;
            pre_cnt_r <= '0;
          end
        end
        ST_PRE: begin
          if (sym_en_r && multi_act) begin
            state_r <= ST_JAM;
          end else if (step) begin
            if (pre_cnt_r == PCW'(PRE_NIB - 1)) begin
              state_r <= ST_SFD;
            end else begin
              pre_cnt_r <= pre_cnt_r + PCW'(1);
            end
          end
        end
        ST_SFD: begin
          if (sym_en_r && multi_act) begin
            state_r <= ST_JAM;
          end else if (step) begin
            state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (sym_en_r && multi_act) begin
            // contention overrides forwarding and error passing
            state_r <= ST_JAM;
          end else if (step && !pop_valid && !src_act) begin
            // source ended and buffer drained
            state_r <= ST_IDLE;
          end
        end
        ST_JAM: begin
          // jam stays until every enabled, healthy port has gone quiet
          if (sym_en_r && !any_act) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // error substitution sticky. it is only cleared in idle, so a
  // violation popped in data state can never meet a clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sub_r <= 1'b0;
    end else if (pop_ready && pop_valid && pop_word.viol) begin
      sub_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      sub_r <= 1'b0;
    end
  end

  // registered copy of buffer space for the status output
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= push_ready;
    end
  end

  // ---------------------------------------------------------------
  // status outputs: rx_ready_out and src_port_out straight from flip-flops, the rest decoded from state_r
  // ---------------------------------------------------------------
  assign rx_ready_out   = ready_r;
  assign collision_out  = (state_r == ST_JAM);
  assign fwd_active_out = (state_r != ST_IDLE) & (state_r != ST_JAM);
  assign src_port_out   = src_r;
endmodule

// ===== bench/multiport_repeater_core_properties.sv
`timescale 1ns/1ns
// port-level checks of forwarding, substitution and jam behaviour
module multiport_repeater_core_properties #(
  parameter int NPORTS = 4
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_n_in,
  input  rep_pkg::rx_port_t  [NPORTS-1:0] rx_port_in,
  input  rep_pkg::port_ctl_t [NPORTS-1:0] port_ctl_in,
  input  wire logic                       tx_ready_in,
  input  rep_pkg::tx_port_t  [NPORTS-1:0] tx_port_out,
  input  wire logic                       rx_ready_out,
  input  wire logic                       collision_out,
  input  wire logic                       fwd_active_out,
  input  wire logic          [NPORTS-1:0] src_port_out
);
  import rep_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  jam_not_fwd_a: assert property (collision_out |-> !fwd_active_out)
    else $error("jam and forwarding at once");
  src_onehot_a: assert property (fwd_active_out |-> $onehot(src_port_out))
    else $error("source port not one-hot");
  // six ready cycles always contain a step, so jam must show by then
  jam_hold_a: assert property ((collision_out && tx_ready_in && !port_ctl_in[0].jab
    && !port_ctl_in[0].unst) [*6] |-> tx_port_out[0].kind == MSG_JAM)
    else $error("jam missing during collision");
  jam_end_a: assert property ($fell(collision_out) |-> ##[0:8]
    (tx_port_out[0].kind != MSG_JAM || !tx_ready_in)) else $error("jam outlasts collision");
  for (genvar g = 0; g < NPORTS; g++) begin : per_port
    blocked_idle_a: assert property (((port_ctl_in[g].jab || port_ctl_in[g].unst)
      && tx_ready_in) [*6] |-> tx_port_out[g].kind == MSG_IDLE) else $error("blocked port driven");
    src_idle_a: assert property (fwd_active_out && src_port_out[g] |->
      tx_port_out[g].kind == MSG_IDLE) else $error("source port echoed");
    err_sticky_a: assert property (fwd_active_out && tx_port_out[g].kind == MSG_ERR |=>
      tx_port_out[g].kind inside {MSG_ERR, MSG_IDLE, MSG_JAM}) else $error("substitution stopped");
    sfd_after_pre_a: assert property (tx_port_out[g].kind == MSG_SFD
      && $past(tx_port_out[g].kind) != MSG_SFD |-> $past(tx_port_out[g].kind) == MSG_PRE)
      else $error("delimiter without preamble");
    err_code_a: assert property (tx_port_out[g].kind == MSG_ERR |-> tx_port_out[g].data ==
      ((port_ctl_in[g].ptype == PHY_T4) ? ERR_SEL_BAD : (port_ctl_in[g].ptype == PHY_T2) ?
      ERR_SEL_ESC : ERR_SEL_H)) else $error("wrong error code-group");
  end
  cover property ($rose(collision_out));
  cover property ($rose(fwd_active_out));
  cover property (tx_port_out[1].kind == MSG_ERR);
  cover property (!rx_ready_out);
endmodule
bind multiport_repeater_core multiport_repeater_core_properties #(.NPORTS(NPORTS))
  i_multiport_repeater_core_properties (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .rx_port_in(rx_port_in), .port_ctl_in(port_ctl_in), .tx_ready_in(tx_ready_in),
  .tx_port_out(tx_port_out), .rx_ready_out(rx_ready_out), .collision_out(collision_out),
  .fwd_active_out(fwd_active_out), .src_port_out(src_port_out));

// ===== bench/rep_pma_model.sv
`timescale 1ns/1ns
// receive sides of the PHYs on every port; each nibble stands one symbol
module rep_pma_model #(
  parameter int NP = 4
) (
  input  wire logic                  clk_sys_in,
  output rep_pkg::rx_port_t [NP-1:0] rx_out
);
  import rep_pkg::*;
  // carrier off at time zero
  initial rx_out = '0;
  // one nibble, changed at the falling edge and held four clocks
  task automatic put(input int p, input logic a, input logic f, input logic v,
                     input logic [3:0] d);
    @(negedge clk_sys_in);
    rx_out[p] = '{a, f, v, d};
    repeat (3) @(negedge clk_sys_in);
  endtask
  // preamble ending in the delimiter, the frame, then carrier drops
  task automatic send(input int p, input int npre, input logic [3:0] frm [$],
                      input int vpos);
    for (int i = 0; i < npre; i++)
      put(p, 1'b1, 1'b0, 1'b0, (i == npre - 1) ? SFD_VAL : PRE_VAL);
    for (int i = 0; i < frm.size(); i++)
      put(p, 1'b1, 1'b1, i == vpos, frm[i]);
    // last nibble stands its full four clocks, or a late symbol pulse misses it
    @(negedge clk_sys_in);
    // released line shows the inverse, so a stale nibble cannot pass as data
    rx_out[p] = '{1'b0, 1'b0, 1'b0, ~frm[frm.size() - 1]};
  endtask
endmodule

// ===== bench/multiport_repeater_core_bench.sv
`timescale 1ns/1ns
// reference streams per port are built from the frame that the PHY model sends
module multiport_repeater_core_bench;
  import rep_pkg::*;
  localparam int NP = 4;
  localparam tx_port_t IDLE_TX = '{MSG_IDLE, IDLE_NIB};
  localparam tx_port_t JAM_TX  = '{MSG_JAM, JAM_VAL};
  logic               clk_sys_in, rst_n_in, tx_ready_in;
  rx_port_t  [NP-1:0] rx_port_in;
  port_ctl_t [NP-1:0] port_ctl_in;
  tx_port_t  [NP-1:0] tx_port_out;
  logic               rx_ready_out, collision_out, fwd_active_out;
  logic      [NP-1:0] src_port_out;
  int                 fails = 0, checked = 0, seed = 75592;
  int                 ph = 0;                 // clocks since the last symbol pulse
  logic               lock = 1'b0, stp = 1'b0; // phase known, last pulse stepped
  logic               mon_on = 1'b0, rr_low;  // sampling on, buffer refused
  logic      [3:0]    frm [$];                // frame of the last packet
  tx_port_t           got [NP][$], exp_q [NP][$];
  multiport_repeater_core #(.NPORTS(NP)) i_multiport_repeater_core (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .rx_port_in(rx_port_in),
    .port_ctl_in(port_ctl_in), .tx_ready_in(tx_ready_in), .tx_port_out(tx_port_out),
    .rx_ready_out(rx_ready_out), .collision_out(collision_out),
    .fwd_active_out(fwd_active_out), .src_port_out(src_port_out));
  rep_pma_model #(.NP(NP)) i_rep_pma_model (.clk_sys_in(clk_sys_in), .rx_out(rx_port_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // phase is locked from the first forwarding start; sample one clock after each step
  always @(posedge clk_sys_in) begin
    if (!lock && fwd_active_out === 1'b1) begin
      lock = 1'b1;
      ph = 2;
    end else ph = (ph + 1) % 4;
    // ready as seen at the symbol edge itself decides whether outputs moved
    if (ph == 1) stp = tx_ready_in;
    if (ph == 2 && stp && mon_on)
      for (int p = 0; p < NP; p++)
        if (got[p].size() > 0 || tx_port_out[p].kind !== MSG_IDLE) got[p].push_back(tx_port_out[p]);
  end
  task automatic end_of_test();
    $display("compares %0d, errors %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_tx(input tx_port_t g, input tx_port_t e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // bounded wait for forwarding (w 0) or collision (w 1) to reach level v
  task automatic wait_sig(input int w, input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk_sys_in);
      if (((w == 0) ? fwd_active_out : collision_out) === v) break;
    end
    if (i == 400) begin
      fails++;
      $display("mismatch at %0t: wait timed out, got %h want %h", $time, !v, v);
      end_of_test();
    end
  endtask
  function automatic logic [3:0] err_of(input phy_type_t t);
    return (t == PHY_T4) ? ERR_SEL_BAD : (t == PHY_T2) ? ERR_SEL_ESC : ERR_SEL_H;
  endfunction
  // one packet from src; the receiver stalls over the symbol of the last nibble
  task automatic fwd(input int src, input int n, input int vpos, input logic blk);
    logic [3:0] d;
    d = 4'h0;
    frm.delete();
    for (int p = 0; p < NP; p++) begin
      got[p].delete();
      exp_q[p].delete();
    end
    for (int i = 0; i < n; i++) begin
      d = d ^ 4'({$random(seed)} % 15 + 1);
      frm.push_back(d);
    end
    for (int p = 0; p < NP; p++)
      if (!blk && p != src && !port_ctl_in[p].jab && !port_ctl_in[p].unst) begin
        for (int i = 0; i < PRE_NIB; i++) exp_q[p].push_back(tx_port_t'{MSG_PRE, PRE_VAL});
        exp_q[p].push_back(tx_port_t'{MSG_SFD, SFD_VAL});
        for (int i = 0; i < n; i++)
          exp_q[p].push_back((vpos >= 0 && i >= vpos) ? tx_port_t'{MSG_ERR, err_of(port_ctl_in[p].ptype)}
                             : tx_port_t'{MSG_DATA, frm[i]});
        exp_q[p].push_back(IDLE_TX);
      end
    mon_on = 1'b1;
    rr_low = 1'b0;
    fork
      i_rep_pma_model.send(src, 15, frm, vpos);
      begin
        repeat (1 + 4 * (14 + n)) @(negedge clk_sys_in);
        tx_ready_in = 1'b0;
        for (int i = 0; i < 8; i++) begin
          @(negedge clk_sys_in);
          if (i == 3) tx_ready_in = 1'b1;
          if (rx_ready_out === 1'b0) rr_low = 1'b1;
        end
      end
    join
    wait_sig(0, 1'b0);
    repeat (12) @(negedge clk_sys_in);
    mon_on = 1'b0;
    if (!blk) cmp_bit(rr_low, 1'b1);
    if (!blk) cmp_bit(src_port_out === NP'(1 << src), 1'b1);
    for (int p = 0; p < NP; p++) begin
      cmp_bit(got[p].size() >= exp_q[p].size(), 1'b1);
      if (exp_q[p].size() == 0) cmp_bit(got[p].size() == 0, 1'b1);
      for (int i = 0; i < exp_q[p].size() && i < got[p].size(); i++)
        cmp_tx(got[p][i], exp_q[p][i]);
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    tx_ready_in = 1'b1;
    for (int p = 0; p < NP; p++) port_ctl_in[p] = '{1'b1, p == 3, 1'b0, 1'b0, phy_type_t'(p % 3)};
    repeat (6) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    fwd(0, 12, 5, 1'b0);
    fwd(1, 10, -1, 1'b0);
    fwd(2, 12, 0, 1'b0);
    fwd(3, 6, -1, 1'b1);
    // disabled, partitioned, jabbering and unstable sources are not repeated
    for (int k = 0; k < 4; k++) begin
      port_ctl_in[1] = '{k != 0, k == 1, k == 2, k == 3, PHY_T4};
      fwd(1, 6, -1, 1'b1);
    end
    port_ctl_in[1] = '{1'b1, 1'b0, 1'b0, 1'b0, PHY_T4};
    // a second port starts while the first forwards; it also outlasts the first
    port_ctl_in[2].jab = 1'b1;
    fork
      i_rep_pma_model.send(0, 15, frm, -1);
      begin
        repeat (20) @(negedge clk_sys_in);
        i_rep_pma_model.send(1, 15, frm, -1);
      end
      begin
        repeat (90) @(negedge clk_sys_in);
        cmp_bit(collision_out, 1'b1);
        cmp_bit(fwd_active_out, 1'b0);
        for (int p = 0; p < NP; p++) cmp_tx(tx_port_out[p], (p == 2) ? IDLE_TX : JAM_TX);
      end
    join
    wait_sig(1, 1'b0);
    repeat (10) @(negedge clk_sys_in);
    for (int p = 0; p < NP; p++) cmp_tx(tx_port_out[p], IDLE_TX);
    fwd(0, 8, 7, 1'b0);
    end_of_test();
  end
endmodule
